//--- rtl/cable_detect_pkg.sv
package cable_detect_pkg;

    // Clock and timing
    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam int unsigned CLK_PERIOD_PS   = 25_000;
    // Release deadline after reset, seconds
    localparam int unsigned RELEASE_TIMEOUT_S = 31;
    localparam longint unsigned RELEASE_TIMEOUT_CYC =
        longint'(RELEASE_TIMEOUT_S) * longint'(CLK_HZ);
    // Device 1 release bound after reset, ns (longest time, rounds down)
    localparam int unsigned DEV1_RELEASE_NS  = 400;
    localparam int unsigned DEV1_RELEASE_CYC =
        (DEV1_RELEASE_NS * 1000) / CLK_PERIOD_PS;
    // Discharge hold (capacitor discharge up to 28 us, least time)
    localparam int unsigned DISCHARGE_NS  = 28_000;
    localparam int unsigned DISCHARGE_CYC =
        (DISCHARGE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Sample window opens 0.3 us after release (least time)
    localparam int unsigned WIN_OPEN_NS   = 300;
    localparam int unsigned WIN_OPEN_CYC  =
        (WIN_OPEN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Sample window closes 7.4 us after release (longest time)
    localparam int unsigned WIN_CLOSE_NS  = 7_400;
    localparam int unsigned WIN_CLOSE_CYC =
        (WIN_CLOSE_NS * 1000) / CLK_PERIOD_PS;

    localparam int unsigned SEQ_CNT_W = 11;
    localparam int unsigned SYNC_STAGES = 2;

    // Cable report encoding
    localparam logic CABLE_40 = 1'h0;
    localparam logic CABLE_80 = 1'h1;

    typedef enum logic [4:0] {
        ST_IDLE      = 5'h01,
        ST_DISCHARGE = 5'h02,
        ST_SETTLE    = 5'h04,
        ST_SAMPLE    = 5'h08,
        ST_DONE      = 5'h10
    } detect_state_e;

    // Firmware direct control of the line
    typedef struct packed {
        logic override;
        logic assert_low;
    } fw_line_s;

    // Result handed to identify data
    typedef struct packed {
        logic valid;
        logic cable_80;
    } cable_result_s;

endpackage

//--- rtl/release_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Counts from reset to a deadline, raising expired as a level
module release_timer
    import cable_detect_pkg::*;
#(
    parameter longint unsigned LIMIT = RELEASE_TIMEOUT_CYC
)(
    input  wire logic clk,
    input  wire logic rst_n,
    output logic      expired
);
    localparam int unsigned W = $clog2(LIMIT + 1);

    initial
    begin
        if (LIMIT < 1)
            $error("release_timer LIMIT must be at least 1");
    end

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         exp_q;
    logic         exp_d;

    always_comb
    begin
        cnt_d = cnt_q;
        exp_d = exp_q;
        if (!exp_q)
        begin
            cnt_d = cnt_q + W'(1);
            if (cnt_q == W'(LIMIT - 1))
                exp_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= '0;
            exp_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            exp_q <= exp_d;
        end
    end

    assign expired = exp_q;
endmodule
`default_nettype wire

//--- rtl/cable_detect.sv
// Behaviour
// RULE1 - Release the line on first command or 31 s after reset.
// RULE2 - Host identifies Device 1 first so the shared line is released.
// RULE3 - Host reads high as 40-conductor, low as probable 80-conductor.
// RULE4 - Host checks identify data shows ATA-3 or later before trusting.
// RULE5 - Host limits Ultra DMA to mode 2 without an 80-conductor cable.
// RULE6 - On identify, drive low, release, sample in window, then answer.
// RULE7 - Sampled cable type is recorded in identify data.
// RULE8 - Host uses each device's reported cable type to allow fast modes.
// RULE9 - As Device 1, release diagnostic line within 400 ns of reset.
// RULE10 - Line is only driven low or released, never driven high.
// RULE11 - Device can assert and sense the line; firmware has direct control.
// RULE12 - Window sample low means 40-conductor, high means 80-conductor.
`timescale 1ns/1ps
`default_nettype none
module cable_detect
    import cable_detect_pkg::*;
#(
    parameter longint unsigned RELEASE_CYC  = RELEASE_TIMEOUT_CYC,
    parameter int unsigned     DISCH_CYC    = DISCHARGE_CYC,
    parameter int unsigned     OPEN_CYC     = WIN_OPEN_CYC,
    parameter int unsigned     CLOSE_CYC    = WIN_CLOSE_CYC
)(
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          is_device1,
    input  wire logic          cmd_strobe,
    input  wire logic          identify_cmd,
    input  wire fw_line_s      fw_line,
    input  wire logic          diag_cable_id_line_i,
    output logic               diag_cable_id_line_o,
    output logic               diag_cable_id_line_oe,
    output logic               line_level,
    output logic               detect_busy,
    output logic               identify_ready,
    output cable_result_s      cable_result
);
    initial
    begin
        if (DISCH_CYC < 1 || OPEN_CYC < 1 || CLOSE_CYC <= OPEN_CYC
            || CLOSE_CYC >= (1 << SEQ_CNT_W) || DISCH_CYC >= (1 << SEQ_CNT_W))
            $error("cable_detect timing parameters out of range");
    end

    // Reset release through two flops
    logic [SYNC_STAGES-1:0] rst_sync_q;
    logic                   rst_i_n;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rst_sync_q <= '0;
        else
            rst_sync_q <= {rst_sync_q[SYNC_STAGES-2:0], 1'b1};
    end
    assign rst_i_n = rst_sync_q[SYNC_STAGES-1];

    logic timeout;
    release_timer #(
        .LIMIT   (RELEASE_CYC)
    ) u_timer (
        .clk     (clk),
        .rst_n   (rst_i_n),
        .expired (timeout)
    );

    // Diagnostic assertion held by a Device 0 after reset
    logic diag_hold_q;
    logic diag_hold_d;
    logic dev1_q;
    logic dev1_d;
    logic strap_q;
    logic strap_d;

    always_comb
    begin
        strap_d     = 1'b1;
        dev1_d      = strap_q ? dev1_q : is_device1;
        diag_hold_d = diag_hold_q;
        if (!strap_q && is_device1)
            diag_hold_d = 1'b0;                           // RULE9
        if (cmd_strobe || timeout)
            diag_hold_d = 1'b0;                           // RULE1
    end

    always_ff @(posedge clk or negedge rst_i_n)
    begin
        if (!rst_i_n)
        begin
            strap_q     <= 1'b0;
            dev1_q      <= 1'b0;
            // Device 1 drops this on the first edge after release
            diag_hold_q <= 1'b1;
        end
        else
        begin
            strap_q     <= strap_d;
            dev1_q      <= dev1_d;
            diag_hold_q <= diag_hold_d;
        end
    end

    // Detection sequencer
    detect_state_e          state_q;
    detect_state_e          state_d;
    logic [SEQ_CNT_W-1:0]   cnt_q;
    logic [SEQ_CNT_W-1:0]   cnt_d;
    cable_result_s          res_q;
    cable_result_s          res_d;
    logic                   rdy_q;
    logic                   rdy_d;

    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        res_d   = res_q;
        rdy_d   = 1'b0;
        unique case (state_q)
            ST_IDLE:
            begin
                if (cmd_strobe && identify_cmd)
                begin
                    state_d = ST_DISCHARGE;               // RULE6
                    cnt_d   = '0;
                end
            end
            ST_DISCHARGE:
            begin
                cnt_d = cnt_q + SEQ_CNT_W'(1);
                if (cnt_q == SEQ_CNT_W'(DISCH_CYC - 1))
                begin
                    state_d = ST_SETTLE;
                    cnt_d   = '0;
                end
            end
            ST_SETTLE:
            begin
                cnt_d = cnt_q + SEQ_CNT_W'(1);
                // Sample one cycle after window open: 80-wire rise is done by then
                if (cnt_q == SEQ_CNT_W'(OPEN_CYC - 1))
                    state_d = ST_SAMPLE;
            end
            ST_SAMPLE:
            begin
                res_d.valid    = 1'b1;                    // RULE7
                res_d.cable_80 = diag_cable_id_line_i ? CABLE_80
                                                      : CABLE_40; // RULE12
                state_d        = ST_DONE;
            end
            ST_DONE:
            begin
                rdy_d   = 1'b1;                           // RULE6
                state_d = ST_IDLE;
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_i_n)
    begin
        if (!rst_i_n)
        begin
            state_q <= ST_IDLE;
            cnt_q   <= '0;
            res_q   <= '0;
            rdy_q   <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            res_q   <= res_d;
            rdy_q   <= rdy_d;
        end
    end

    // Open-drain drive: output data is always low
    logic drive_low;
    always_comb
    begin
        if (fw_line.override)
            drive_low = fw_line.assert_low;               // RULE11
        else
            drive_low = diag_hold_q || (state_q == ST_DISCHARGE);
    end

    assign diag_cable_id_line_o  = 1'b0;                  // RULE10
    assign diag_cable_id_line_oe = drive_low;             // RULE10
    assign line_level            = diag_cable_id_line_i;  // RULE11
    assign detect_busy           = (state_q != ST_IDLE);
    assign identify_ready        = rdy_q;
    assign cable_result          = res_q;

endmodule
`default_nettype wire

//--- sim/cable_detect_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module cable_detect_assertions
    import cable_detect_pkg::*;
#(
    parameter int unsigned DISCH_CYC = DISCHARGE_CYC,
    parameter int unsigned OPEN_CYC  = WIN_OPEN_CYC
)(
    input wire logic          clk,
    input wire logic          rst_n,
    input wire logic          is_device1,
    input wire logic          cmd_strobe,
    input wire logic          identify_cmd,
    input wire fw_line_s      fw_line,
    input wire logic          diag_cable_id_line_o,
    input wire logic          diag_cable_id_line_oe,
    input wire logic          detect_busy,
    input wire logic          identify_ready,
    input wire cable_result_s cable_result
);
    // Edges from the taken strobe to the edge that samples ready high
    localparam int ANS = DISCH_CYC + OPEN_CYC + 3;
    logic [15:0] since_q;
    // Counter instead of a long delay, which the default timing exceeds
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            since_q <= '0;
        else if (cmd_strobe && identify_cmd && !detect_busy)
            since_q <= 16'h1;
        else if (identify_ready)
            since_q <= '0;
        else if (since_q != 16'h0)
            since_q <= since_q + 16'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_never_high: assert property (diag_cable_id_line_o == 1'b0)
        else $error("line driven high");
    a_fw_direct: assert property (fw_line.override |->
        diag_cable_id_line_oe == fw_line.assert_low)
        else $error("firmware control ignored");
    a_dev1_release: assert property ($rose(rst_n) && is_device1 |->
        ##[1:16] !diag_cable_id_line_oe)
        else $error("device 1 hold too long");
    a_cmd_release: assert property (cmd_strobe && !identify_cmd &&
        !detect_busy && !fw_line.override |-> ##[1:3] !diag_cable_id_line_oe)
        else $error("hold kept after command");
    a_answer_time: assert property (identify_ready ==
        (since_q == 16'(ANS)))
        else $error("identify answer late or early");
    a_discharge: assert property ($rose(detect_busy) && !fw_line.override
        |-> diag_cable_id_line_oe [*8])
        else $error("discharge too short");
    a_ready_valid: assert property (identify_ready |->
        cable_result.valid ##1 !identify_ready)
        else $error("answer without result");
endmodule
bind cable_detect cable_detect_assertions #(
    .DISCH_CYC(DISCH_CYC), .OPEN_CYC(OPEN_CYC)) u_chk (.*);
`default_nettype wire

//--- sim/cable_far_end.sv
`timescale 1ns/1ps
`default_nettype none
// Host side: pull-up plus optional host capacitor on the shared line
module cable_far_end (
    input wire logic clk,
    input wire logic oe,
    input wire logic cap,
    output logic     line
);
    int chg_q;
    always_ff @(posedge clk)
    begin
        chg_q <= oe ? 0 : (chg_q < 40 ? chg_q + 1 : chg_q);
    end
    // Capacitor holds the line low 10 cycles, past the sample point
    assign line = !oe && (!cap || chg_q >= 10);
endmodule
`default_nettype wire

//--- sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import cable_detect_pkg::*;
    typedef struct packed {logic cap; logic exp;} row_s;
    logic clk = 0, rst_n = 0, is_device1 = 0, cmd_strobe = 0;
    logic identify_cmd = 0, cap = 0;
    fw_line_s fw_line = '0;
    logic diag_cable_id_line_i, diag_cable_id_line_o, diag_cable_id_line_oe;
    logic line_level, detect_busy, identify_ready;
    cable_result_s cable_result;
    int n_mismatch = 0, num_checks = 0, cyc = 0;
    row_s rows [3] = '{'{1'b1, CABLE_40}, '{1'b0, CABLE_80},
        '{1'b1, CABLE_40}};
    cable_detect #(.RELEASE_CYC(100), .DISCH_CYC(20), .OPEN_CYC(4),
        .CLOSE_CYC(10)) dut (.*);
    cable_far_end far (.clk(clk), .oe(diag_cable_id_line_oe), .cap(cap),
        .line(diag_cable_id_line_i));
    initial forever #12.5 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 1000)
        begin
            n_mismatch++;
            wrap_up();
        end
    end
    task automatic chk(input logic [1:0] got, input logic [1:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %b want %b", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic reset(input logic dev1);
        rst_n = 0;
        is_device1 = dev1;
        repeat (8) @(negedge clk);
        rst_n = 1;
    endtask
    task automatic cmd(input logic id);
        @(negedge clk);
        cmd_strobe = 1;
        identify_cmd = id;
        @(negedge clk);
        cmd_strobe = 0;
        identify_cmd = 0;
    endtask
    task automatic ident(input logic exp);
        int i;
        cmd(1'b1);
        chk({detect_busy, diag_cable_id_line_oe}, 2'h3);
        for (i = 0; i < 60 && identify_ready !== 1'b1; i++)
            @(posedge clk) #1;
        chk({1'b0, identify_ready}, 2'h1);
        chk(cable_result, {1'b1, exp});
        chk({1'b0, cable_result.valid && cable_result.cable_80},
            {1'b0, exp == CABLE_80});
    endtask
    initial
    begin
        reset(1'b0);
        repeat (20) @(negedge clk);
        chk({diag_cable_id_line_o, diag_cable_id_line_oe}, 2'h1);
        repeat (100) @(negedge clk);
        chk({diag_cable_id_line_o, diag_cable_id_line_oe}, 2'h0);
        reset(1'b0);
        repeat (4) @(negedge clk);
        cmd(1'b0);
        @(negedge clk);
        chk({1'b0, diag_cable_id_line_oe}, 2'h0);
        reset(1'b1);
        repeat (16) @(negedge clk);
        chk({1'b0, diag_cable_id_line_oe}, 2'h0);
        // Back to back: next identify follows each answer at once
        foreach (rows[k])
        begin
            cap = rows[k].cap;
            ident(rows[k].exp);
        end
        @(negedge clk);
        cap = 0;
        fw_line = '{1'b1, 1'b1};
        repeat (2) @(negedge clk);
        chk({diag_cable_id_line_oe, line_level}, 2'h2);
        fw_line = '{1'b1, 1'b0};
        repeat (2) @(negedge clk);
        chk({diag_cable_id_line_oe, line_level}, 2'h1);
        fw_line = '0;
        wrap_up();
    end
endmodule
`default_nettype wire
